// ---- hdl/sx_excl_mon.sv ----
`timescale 1ns/100ps
module sx_excl_mon (
  input  wire logic i_mclk,
  input  wire logic i_reset_n,
  sx_mon_if.mon     mon
);
  import sx_pkg::*;

  logic        valid_ff;
  logic        nxt_valid;
  logic [31:0] addr_ff;
  logic [31:0] nxt_addr;
  sx_size_type size_ff;
  sx_size_type nxt_size;
  logic        snoop_hit;

  // ------------------------------------------------------------
  // local monitor
  // ------------------------------------------------------------
  // word granule: any foreign touch of the word breaks the reservation
  assign snoop_hit = mon.snoop &&
                     mon.snoop_addr[31:SX_WORD_LSB] == addr_ff[31:SX_WORD_LSB];
  // a differing address or size simply fails
  assign mon.hit   = valid_ff && mon.addr == addr_ff && mon.size == size_ff;

  always_comb begin
    nxt_valid = valid_ff;
    nxt_addr  = addr_ff;
    nxt_size  = size_ff;
    if (mon.set) begin
      nxt_valid = 1'b1;
      nxt_addr  = mon.addr;
      nxt_size  = mon.size;
    end else if (mon.clr || snoop_hit) begin
      nxt_valid = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      valid_ff <= 1'b0;
      addr_ff  <= 32'h0;
      size_ff  <= SZ_WORD;
    end else begin
      valid_ff <= nxt_valid;
      addr_ff  <= nxt_addr;
      size_ff  <= nxt_size;
    end
  end

  a_clear_drops: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    mon.clr && !mon.set |=> !valid_ff)
    else $error("monitor still set after clear");
  a_snoop_drops: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    snoop_hit && !mon.set |=> !mon.hit)
    else $error("reservation survived foreign access");
endmodule

// ---- hdl/sx_list_scan.sv ----
`timescale 1ns/100ps
module sx_list_scan #(
  parameter int N  = 16,
  parameter int IW = 4
) (
  input  wire logic [N-1:0]  i_list,
  output logic      [IW-1:0] o_lo,
  output logic      [IW-1:0] o_hi,
  output logic               o_any
);
  // lowest and highest listed register
  always_comb begin
    o_lo  = '0;
    o_hi  = '0;
    o_any = |i_list;
    for (int i = N - 1; i >= 0; i--) begin
      if (i_list[i]) begin
        o_lo = IW'(i);
      end
    end
    for (int i = 0; i < N; i++) begin
      if (i_list[i]) begin
        o_hi = IW'(i);
      end
    end
  end
endmodule

// ---- hdl/sx_mon_if.sv ----
`timescale 1ns/100ps
interface sx_mon_if;
  import sx_pkg::*;
  logic        set;
  logic        clr;
  logic        snoop;
  logic [31:0] addr;
  logic [31:0] snoop_addr;
  sx_size_type size;
  logic        hit;
  modport core (output set, clr, snoop, addr, snoop_addr, size, input hit);
  modport mon  (input set, clr, snoop, addr, snoop_addr, size, output hit);
endinterface

// ---- hdl/sx_pkg.sv ----
package sx_pkg;
  // ------------------------------------------------------------
  // widths and fixed values
  // ------------------------------------------------------------
  localparam int          SX_XLEN        = 32;
  localparam int          SX_NREGS       = 16;
  localparam int          SX_RIDX_W      = 4;
  localparam logic [31:0] SX_WORD_STEP   = 32'h4;
  localparam logic [3:0]  SX_PC_IDX      = 4'hf;
  localparam logic [31:0] SX_STATUS_OK   = 32'h0;
  localparam logic [31:0] SX_STATUS_FAIL = 32'h1;
  localparam int          SX_TBIT_POS    = 0;
  localparam int          SX_WORD_LSB    = 2;
  localparam int          SX_BYTE_MSB    = 7;
  localparam int          SX_HALF_MSB    = 15;

  // ------------------------------------------------------------
  // commands and access sizes
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_PUSH,
    OP_POP,
    OP_LDEX,
    OP_STEX,
    OP_CLEAR_EXCLUSIVE
  } sx_op_type;

  typedef enum logic [1:0] {
    SZ_WORD,
    SZ_HALF,
    SZ_BYTE
  } sx_size_type;
endpackage

// ---- hdl/sx_stack_excl.sv ----
// Notes on behaviour
// - push stores highest register first, descending addresses
// - pop loads lowest register first, ascending addresses
// - push starts at stack pointer minus four
// - pop starts at stack pointer itself
// - stack pointer ends at lowest/above-highest word
// - popped program counter branches after pop completes
// - popped bit zero sets state bit, halfword target
// - these operations never touch condition flags
// - exclusive loads fetch word, byte or halfword
// - store status zero if stored, one otherwise
// - success means nobody touched the location
// - mismatched store address or size fails, status one
// - after clear, next exclusive store fails
`timescale 1ns/100ps
module sx_stack_excl (
  input  wire logic                i_mclk,
  input  wire logic                i_reset_n,
  input  wire logic                i_cmd_valid,
  input  wire sx_pkg::sx_op_type   i_cmd_op,
  input  wire sx_pkg::sx_size_type i_cmd_size,
  input  wire logic [15:0]         i_reg_list,
  input  wire logic [31:0]         i_sp,
  input  wire logic [31:0]         i_base,
  input  wire logic [31:0]         i_offset,
  input  wire logic [3:0]          i_xfer_reg,
  input  wire logic [3:0]          i_status_reg,
  input  wire logic [31:0]         i_store_data,
  input  wire logic [31:0]         i_rf_rdata,
  input  wire logic                i_mem_ack,
  input  wire logic [31:0]         i_mem_rdata,
  input  wire logic                i_snoop_valid,
  input  wire logic [31:0]         i_snoop_addr,
  output logic                     o_busy,
  output logic                     o_done,
  output logic [3:0]               o_rf_raddr,
  output logic                     o_rf_we,
  output logic [3:0]               o_rf_waddr,
  output logic [31:0]              o_rf_wdata,
  output logic                     o_mem_req,
  output logic                     o_mem_we,
  output logic [31:0]              o_mem_addr,
  output logic [31:0]              o_mem_wdata,
  output sx_pkg::sx_size_type      o_mem_size,
  output logic                     o_sp_we,
  output logic [31:0]              o_sp_wdata,
  output logic                     o_branch,
  output logic [31:0]              o_branch_addr,
  output logic                     o_tbit,
  output logic                     o_flags_we
);
  import sx_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE,
    S_RDREG,
    S_ISSUE,
    S_WAIT,
    S_FIN
  } sx_state_type;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  sx_state_type state_ff,    nxt_state;
  sx_op_type    op_ff,       nxt_op;
  sx_size_type  size_ff,     nxt_size;
  logic [15:0]  list_ff,     nxt_list;
  logic [31:0]  addr_ff,     nxt_addr;
  logic [3:0]   cur_ff,      nxt_cur;
  logic [3:0]   xreg_ff,     nxt_xreg;
  logic [3:0]   sreg_ff,     nxt_sreg;
  logic [31:0]  pc_ff,       nxt_pc;
  logic         pc_pend_ff,  nxt_pc_pend;
  logic         busy_ff,     nxt_busy;
  logic         done_ff,     nxt_done;
  logic [3:0]   raddr_ff,    nxt_raddr;
  logic         rf_we_ff,    nxt_rf_we;
  logic [3:0]   rf_waddr_ff, nxt_rf_waddr;
  logic [31:0]  rf_wdata_ff, nxt_rf_wdata;
  logic         req_ff,      nxt_req;
  logic         we_ff,       nxt_we;
  logic [31:0]  wdata_ff,    nxt_wdata;
  sx_size_type  msize_ff,    nxt_msize;
  logic         sp_we_ff,    nxt_sp_we;
  logic [31:0]  sp_wdata_ff, nxt_sp_wdata;
  logic         branch_ff,   nxt_branch;
  logic [31:0]  baddr_ff,    nxt_baddr;
  logic         tbit_ff,     nxt_tbit;
  logic         flags_we_ff;

  logic [3:0]   scan_lo;
  logic [3:0]   scan_hi;
  logic         scan_any;
  logic [15:0]  rest;
  logic         take;
  logic [31:0]  eff_addr;

  sx_mon_if mon_bus ();

  sx_list_scan #(
    .N  (SX_NREGS),
    .IW (SX_RIDX_W)
  ) u_scan (
    .i_list (list_ff),
    .o_lo   (scan_lo),
    .o_hi   (scan_hi),
    .o_any  (scan_any)
  );

  sx_excl_mon u_mon (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .mon       (mon_bus.mon)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] load_ext(sx_size_type sz, logic [31:0] d);
    logic [31:0] r;
    r = d;
    if (sz == SZ_BYTE) begin
      r = {24'h0, d[SX_BYTE_MSB:0]};
    end else if (sz == SZ_HALF) begin
      r = {16'h0, d[SX_HALF_MSB:0]};
    end
    return r;
  endfunction

  assign take     = i_cmd_valid && state_ff == S_IDLE;
  assign eff_addr = i_base + i_offset;
  assign rest     = list_ff & ~(16'h1 << cur_ff);

  assign mon_bus.addr       = (state_ff == S_IDLE) ? eff_addr : addr_ff;
  assign mon_bus.size       = (state_ff == S_IDLE) ? i_cmd_size : size_ff;
  assign mon_bus.snoop      = i_snoop_valid;
  assign mon_bus.snoop_addr = i_snoop_addr;
  // every exclusive store or clear drops the reservation, pass or fail
  assign mon_bus.clr = take && (i_cmd_op == OP_STEX || i_cmd_op == OP_CLEAR_EXCLUSIVE);
  assign mon_bus.set = state_ff == S_WAIT && i_mem_ack && op_ff == OP_LDEX;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    nxt_state    = state_ff;
    nxt_op       = op_ff;
    nxt_size     = size_ff;
    nxt_list     = list_ff;
    nxt_addr     = addr_ff;
    nxt_cur      = cur_ff;
    nxt_xreg     = xreg_ff;
    nxt_sreg     = sreg_ff;
    nxt_pc       = pc_ff;
    nxt_pc_pend  = pc_pend_ff;
    nxt_raddr    = raddr_ff;
    nxt_rf_we    = 1'b0;
    nxt_rf_waddr = rf_waddr_ff;
    nxt_rf_wdata = rf_wdata_ff;
    nxt_req      = req_ff;
    nxt_we       = we_ff;
    nxt_wdata    = wdata_ff;
    nxt_msize    = msize_ff;
    nxt_sp_we    = 1'b0;
    nxt_sp_wdata = sp_wdata_ff;
    nxt_branch   = 1'b0;
    nxt_baddr    = baddr_ff;
    nxt_tbit     = tbit_ff;
    nxt_done     = 1'b0;
    case (state_ff)
      S_IDLE: begin
        if (take) begin
          nxt_op      = i_cmd_op;
          nxt_size    = i_cmd_size;
          nxt_list    = i_reg_list;
          nxt_xreg    = i_xfer_reg;
          nxt_sreg    = i_status_reg;
          nxt_pc_pend = 1'b0;
          nxt_state   = S_FIN;
          case (i_cmd_op)
            OP_PUSH: begin
              if (|i_reg_list) begin
                nxt_addr  = i_sp - SX_WORD_STEP;
                nxt_state = S_RDREG;
              end else begin
                nxt_addr = i_sp;
              end
            end
            OP_POP: begin
              nxt_addr = i_sp;
              if (|i_reg_list) begin
                nxt_state = S_ISSUE;
              end
            end
            OP_LDEX: begin
              nxt_addr  = eff_addr;
              nxt_state = S_ISSUE;
            end
            OP_STEX: begin
              nxt_addr = eff_addr;
              if (mon_bus.hit) begin
                nxt_wdata = i_store_data;
                nxt_state = S_ISSUE;
              end else begin
                // no store: memory untouched, status says so
                nxt_rf_we    = 1'b1;
                nxt_rf_waddr = i_status_reg;
                nxt_rf_wdata = SX_STATUS_FAIL;
              end
            end
            default: begin
            end
          endcase
        end
      end
      S_RDREG: begin
        nxt_cur   = scan_hi;
        nxt_raddr = scan_hi;
        nxt_state = S_ISSUE;
      end
      S_ISSUE: begin
        nxt_req   = 1'b1;
        nxt_state = S_WAIT;
        nxt_we    = op_ff == OP_PUSH || op_ff == OP_STEX;
        nxt_msize = (op_ff == OP_PUSH || op_ff == OP_POP) ? SZ_WORD : size_ff;
        if (op_ff == OP_PUSH) begin
          nxt_wdata = i_rf_rdata;
        end
        if (op_ff == OP_POP) begin
          nxt_cur = scan_lo;
        end
      end
      S_WAIT: begin
        if (i_mem_ack) begin
          nxt_req   = 1'b0;
          nxt_we    = 1'b0;
          nxt_state = S_FIN;
          case (op_ff)
            OP_PUSH: begin
              nxt_list = rest;
              if (|rest) begin
                nxt_addr  = addr_ff - SX_WORD_STEP;
                nxt_state = S_RDREG;
              end
            end
            OP_POP: begin
              nxt_list = rest;
              nxt_addr = addr_ff + SX_WORD_STEP;
              if (cur_ff == SX_PC_IDX) begin
                // held back until every load is done
                nxt_pc      = i_mem_rdata;
                nxt_pc_pend = 1'b1;
              end else begin
                nxt_rf_we    = 1'b1;
                nxt_rf_waddr = cur_ff;
                nxt_rf_wdata = i_mem_rdata;
              end
              if (|rest) begin
                nxt_state = S_ISSUE;
              end
            end
            OP_LDEX: begin
              nxt_rf_we    = 1'b1;
              nxt_rf_waddr = xreg_ff;
              nxt_rf_wdata = load_ext(size_ff, i_mem_rdata);
            end
            default: begin
              nxt_rf_we    = 1'b1;
              nxt_rf_waddr = sreg_ff;
              nxt_rf_wdata = SX_STATUS_OK;
            end
          endcase
        end
      end
      S_FIN: begin
        nxt_done  = 1'b1;
        nxt_state = S_IDLE;
        if (op_ff == OP_PUSH || op_ff == OP_POP) begin
          nxt_sp_we    = 1'b1;
          nxt_sp_wdata = addr_ff;
        end
        if (pc_pend_ff) begin
          nxt_branch  = 1'b1;
          nxt_tbit    = pc_ff[SX_TBIT_POS];
          nxt_baddr   = {pc_ff[31:1], 1'b0};
          nxt_pc_pend = 1'b0;
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
    nxt_busy = nxt_state != S_IDLE;
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff    <= S_IDLE;
      op_ff       <= OP_PUSH;
      size_ff     <= SZ_WORD;
      list_ff     <= 16'h0;
      addr_ff     <= 32'h0;
      cur_ff      <= 4'h0;
      xreg_ff     <= 4'h0;
      sreg_ff     <= 4'h0;
      pc_ff       <= 32'h0;
      pc_pend_ff  <= 1'b0;
      busy_ff     <= 1'b0;
      done_ff     <= 1'b0;
      raddr_ff    <= 4'h0;
      rf_we_ff    <= 1'b0;
      rf_waddr_ff <= 4'h0;
      rf_wdata_ff <= 32'h0;
      req_ff      <= 1'b0;
      we_ff       <= 1'b0;
      wdata_ff    <= 32'h0;
      msize_ff    <= SZ_WORD;
      sp_we_ff    <= 1'b0;
      sp_wdata_ff <= 32'h0;
      branch_ff   <= 1'b0;
      baddr_ff    <= 32'h0;
      tbit_ff     <= 1'b0;
      flags_we_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      op_ff       <= nxt_op;
      size_ff     <= nxt_size;
      list_ff     <= nxt_list;
      addr_ff     <= nxt_addr;
      cur_ff      <= nxt_cur;
      xreg_ff     <= nxt_xreg;
      sreg_ff     <= nxt_sreg;
      pc_ff       <= nxt_pc;
      pc_pend_ff  <= nxt_pc_pend;
      busy_ff     <= nxt_busy;
      done_ff     <= nxt_done;
      raddr_ff    <= nxt_raddr;
      rf_we_ff    <= nxt_rf_we;
      rf_waddr_ff <= nxt_rf_waddr;
      rf_wdata_ff <= nxt_rf_wdata;
      req_ff      <= nxt_req;
      we_ff       <= nxt_we;
      wdata_ff    <= nxt_wdata;
      msize_ff    <= nxt_msize;
      sp_we_ff    <= nxt_sp_we;
      sp_wdata_ff <= nxt_sp_wdata;
      branch_ff   <= nxt_branch;
      baddr_ff    <= nxt_baddr;
      tbit_ff     <= nxt_tbit;
      flags_we_ff <= 1'b0;
    end
  end

  assign o_busy        = busy_ff;
  assign o_done        = done_ff;
  assign o_rf_raddr    = raddr_ff;
  assign o_rf_we       = rf_we_ff;
  assign o_rf_waddr    = rf_waddr_ff;
  assign o_rf_wdata    = rf_wdata_ff;
  assign o_mem_req     = req_ff;
  assign o_mem_we      = we_ff;
  assign o_mem_addr    = addr_ff;
  assign o_mem_wdata   = wdata_ff;
  assign o_mem_size    = msize_ff;
  assign o_sp_we       = sp_we_ff;
  assign o_sp_wdata    = sp_wdata_ff;
  assign o_branch      = branch_ff;
  assign o_branch_addr = baddr_ff;
  assign o_tbit        = tbit_ff;
  assign o_flags_we    = flags_we_ff;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [31:0] sp_start_ff;
  logic [4:0]  xfer_cnt_ff;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sp_start_ff <= 32'h0;
      xfer_cnt_ff <= 5'h0;
    end else if (take) begin
      sp_start_ff <= i_sp;
      xfer_cnt_ff <= 5'h0;
    end else if (state_ff == S_WAIT && i_mem_ack) begin
      xfer_cnt_ff <= xfer_cnt_ff + 5'h1;
    end
  end

  a_push_start: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    take && i_cmd_op == OP_PUSH && |i_reg_list |=> o_mem_addr == $past(i_sp) - SX_WORD_STEP)
    else $error("push does not start below stack pointer");
  a_pop_start: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    take && i_cmd_op == OP_POP |=> o_mem_addr == $past(i_sp))
    else $error("pop does not start at stack pointer");
  a_push_descends: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    state_ff == S_WAIT && i_mem_ack && op_ff == OP_PUSH && |rest
    |=> o_mem_addr == $past(o_mem_addr) - SX_WORD_STEP ##1 o_rf_raddr < $past(cur_ff, 2))
    else $error("push order not descending");
  a_pop_ascends: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    state_ff == S_WAIT && i_mem_ack && op_ff == OP_POP && |rest
    |=> o_mem_addr == $past(o_mem_addr) + SX_WORD_STEP ##1 cur_ff > $past(cur_ff, 2))
    else $error("pop order not ascending");
  a_sp_final: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_sp_we |-> o_sp_wdata == ((op_ff == OP_PUSH)
      ? sp_start_ff - {25'h0, xfer_cnt_ff, 2'b00}
      : sp_start_ff + {25'h0, xfer_cnt_ff, 2'b00}))
    else $error("stack pointer final value wrong");
  a_branch_last: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_branch |-> o_sp_we && o_done && !o_mem_req && !$past(o_mem_req))
    else $error("branch before pop completed");
  a_branch_tbit: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_branch |-> !o_branch_addr[SX_TBIT_POS] && o_tbit == pc_ff[SX_TBIT_POS])
    else $error("branch target or state bit wrong");
  a_flags_kept: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !o_flags_we)
    else $error("condition flags written");
  a_stex_fail: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    take && i_cmd_op == OP_STEX && !mon_bus.hit
    |=> o_rf_we && o_rf_wdata == SX_STATUS_FAIL && !o_mem_req ##1 !o_mem_req && o_done)
    else $error("failed exclusive store misreported");
  a_stex_pass: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_rf_we && o_rf_wdata == SX_STATUS_OK && op_ff == OP_STEX |-> $past(o_mem_req && o_mem_we))
    else $error("success status without a store");
  a_ldex_width: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_rf_we && op_ff == OP_LDEX && size_ff == SZ_BYTE |-> o_rf_wdata[31:8] == 24'h0)
    else $error("byte exclusive load not zero extended");
endmodule

// ---- tb/sx_mem_model.sv ----
`timescale 1ns/100ps
module sx_mem_model (
  input  wire logic        i_mclk,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic [1:0]  i_wait,
  output logic             o_ack,
  output logic [31:0]      o_rdata
);
  logic [31:0] mem [0:63];
  logic [1:0]  cnt;

  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 32'h5a000001 + (i << 4);
    end
    o_ack = 1'b0;
    o_rdata = 32'h0;
    cnt = 2'h0;
  end

  // one-cycle ack; read data toggles whenever it is not valid
  always @(posedge i_mclk) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req && !o_ack) begin
      if (cnt == i_wait) begin
        o_ack <= 1'b1;
        cnt <= 2'h0;
        o_rdata <= mem[i_addr[7:2]];
        if (i_we) begin
          mem[i_addr[7:2]] <= i_wdata;
        end
      end else begin
        cnt <= cnt + 2'h1;
      end
    end
  end
endmodule

// ---- tb/sx_stack_excl_tb.sv ----
`timescale 1ns/100ps
module sx_stack_excl_tb;
  import sx_pkg::*;
  logic        i_mclk, i_reset_n, i_cmd_valid, i_snoop_valid, i_mem_ack;
  sx_op_type   i_cmd_op;
  sx_size_type i_cmd_size, o_mem_size, sz_got;
  logic [15:0] i_reg_list;
  logic [31:0] i_sp, i_base, i_offset, i_store_data, i_snoop_addr, i_rf_rdata;
  logic [31:0] i_mem_rdata, o_rf_wdata, o_mem_addr, o_mem_wdata, o_sp_wdata;
  logic [31:0] o_branch_addr, stk_got, br_got;
  logic [3:0]  i_xfer_reg, i_status_reg, o_rf_raddr, o_rf_waddr;
  logic        o_busy, o_done, o_rf_we, o_mem_req, o_mem_we, o_sp_we;
  logic        o_branch, o_tbit, o_flags_we, tb_got;
  logic [1:0]  mwait;
  int          err_count, checked, br_seen;
  logic [31:0] q_ma[$], q_md[$], q_rd[$];
  logic        q_mw[$];
  logic [3:0]  q_ra[$];

  assign i_rf_rdata = 32'h77000000 | {28'h0, o_rf_raddr};

  sx_stack_excl sx_stack_excl_i (.*);
  sx_mem_model sx_mem_model_i (.i_mclk(i_mclk), .i_req(o_mem_req), .i_we(o_mem_we),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_wait(mwait), .o_ack(i_mem_ack),
    .o_rdata(i_mem_rdata));

  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // sampled mid-cycle so every registered output has settled
  always @(negedge i_mclk) begin
    if (o_mem_req && i_mem_ack) begin
      q_ma.push_back(o_mem_addr);
      q_md.push_back(o_mem_wdata);
      q_mw.push_back(o_mem_we);
      sz_got = o_mem_size;
    end
    if (o_rf_we) begin
      q_ra.push_back(o_rf_waddr);
      q_rd.push_back(o_rf_wdata);
    end
    if (o_sp_we) stk_got = o_sp_wdata;
    if (o_branch) begin
      br_got = o_branch_addr;
      tb_got = o_tbit;
      br_seen = q_ma.size();
    end
    if (o_flags_we !== 1'b0) chk(1'b0, "flags written");
  end

  task automatic issue(input sx_op_type op, input sx_size_type sz, input logic [15:0] rl,
                       input logic [31:0] a, input logic [3:0] st, input logic [31:0] d);
    int n;
    q_ma.delete();
    q_md.delete();
    q_mw.delete();
    q_ra.delete();
    q_rd.delete();
    br_seen = -1;
    stk_got = 32'hdeadbeef;
    @(negedge i_mclk);
    i_cmd_op = op;
    i_cmd_size = sz;
    i_reg_list = rl;
    i_sp = a;
    i_base = a;
    i_status_reg = st;
    i_store_data = d;
    i_cmd_valid = 1'b1;
    @(negedge i_mclk);
    i_cmd_valid = 1'b0;
    chk(o_busy === 1'b1, "busy not raised after take");
    for (n = 0; n < 300 && o_done !== 1'b1; n++) @(negedge i_mclk);
    @(negedge i_mclk);
    chk(n < 300 && o_busy === 1'b0, "command never completed");
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_push;
    mwait = 2'h1;
    issue(OP_PUSH, SZ_WORD, 16'h0089, 32'h100, 4'h0, 32'h0);
    chk(q_ma.size() == 3 && q_mw[0] === 1'b1 && sz_got === SZ_WORD, "push count");
    chk(q_ma[0] === 32'hfc && q_md[0] === 32'h77000007, "push first");
    chk(q_ma[1] === 32'hf8 && q_md[1] === 32'h77000003, "push middle");
    chk(q_ma[2] === 32'hf4 && q_md[2] === 32'h77000000, "push last");
    chk(stk_got === 32'hf4, "push stack top");
    $display("test push done");
  endtask

  task automatic t_pop;
    mwait = 2'h2;
    issue(OP_POP, SZ_WORD, 16'h8024, 32'h200, 4'h0, 32'h0);
    chk(q_ma.size() == 3 && q_mw[1] === 1'b0, "pop count");
    chk(q_ma[0] === 32'h200 && q_ma[2] === 32'h208, "pop order");
    chk(q_ra[0] === 4'h2 && q_rd[0] === 32'h5a000001, "pop low");
    chk(q_ra[1] === 4'h5 && q_rd[1] === 32'h5a000011, "pop high");
    chk(stk_got === 32'h20c, "pop stack top");
    chk(br_seen == 3, "branch before pop end");
    chk(br_got === 32'h5a000020 && tb_got === 1'b1, "branch target");
    $display("test pop done");
  endtask

  task automatic t_ldex;
    sx_size_type szs[3] = '{SZ_WORD, SZ_HALF, SZ_BYTE};
    logic [31:0] ex[3] = '{32'h5a000121, 32'h0121, 32'h21};
    mwait = 2'h0;
    for (int k = 0; k < 3; k++) begin
      issue(OP_LDEX, szs[k], 16'h0, 32'h40, 4'h0, 32'h0);
      chk(q_ma[0] === 32'h48 && sz_got === szs[k], "load address");
      chk(q_ra[0] === 4'h6 && q_rd[0] === ex[k], "load data");
    end
    $display("test load done");
  endtask

  task automatic t_stex;
    issue(OP_LDEX, SZ_WORD, 16'h0, 32'h40, 4'h0, 32'h0);
    issue(OP_STEX, SZ_WORD, 16'h0, 32'h40, 4'h4, 32'hcafe0000);
    chk(q_ma[0] === 32'h48 && q_md[0] === 32'hcafe0000, "store write");
    chk(q_ra[0] === 4'h4 && q_rd[0] === SX_STATUS_OK, "store status");
    issue(OP_STEX, SZ_WORD, 16'h0, 32'h40, 4'h4, 32'h0);
    chk(q_ma.size() == 0 && q_rd[0] === SX_STATUS_FAIL, "second store");
    $display("test store done");
  endtask

  // a foreign access, then a clear, must each break the reservation
  task automatic t_fail;
    for (int k = 0; k < 2; k++) begin
      issue(OP_LDEX, SZ_HALF, 16'h0, 32'h40, 4'h0, 32'h0);
      if (k == 0) begin
        i_snoop_addr = 32'h4a;
        i_snoop_valid = 1'b1;
        @(negedge i_mclk);
        i_snoop_valid = 1'b0;
      end else begin
        issue(OP_CLEAR_EXCLUSIVE, SZ_HALF, 16'h0, 32'h40, 4'h0, 32'h0);
        chk(q_ma.size() == 0, "clear touched memory");
      end
      issue(OP_STEX, SZ_HALF, 16'h0, 32'h40, 4'h3, 32'h1234);
      chk(q_ma.size() == 0, "failed store wrote");
      chk(q_ra[0] === 4'h3 && q_rd[0] === SX_STATUS_FAIL, "fail status");
    end
    $display("test fail done");
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // scenarios need well under 1000 cycles; allow 20000
  initial begin
    #400000;
    err_count++;
    print_verdict;
  end

  initial begin
    err_count = 0;
    checked = 0;
    mwait = 2'h0;
    i_reset_n = 1'b0;
    i_cmd_valid = 1'b0;
    i_cmd_op = OP_PUSH;
    i_cmd_size = SZ_WORD;
    i_reg_list = 16'h0;
    i_sp = 32'h0;
    i_base = 32'h0;
    i_offset = 32'h8;
    i_xfer_reg = 4'h6;
    i_status_reg = 4'h0;
    i_store_data = 32'h0;
    i_snoop_valid = 1'b0;
    i_snoop_addr = 32'h0;
    repeat (16) @(posedge i_mclk);
    @(negedge i_mclk);
    i_reset_n = 1'b1;
    t_push;
    t_pop;
    t_ldex;
    t_stex;
    t_fail;
    print_verdict;
  end
endmodule
